// *** acs_pkg.sv ***
package acs_pkg;

    localparam int unsigned NUM_CH = 16;

    // Serial port register map
    localparam logic [5:0] ADDR_STATUS   = 6'h00;
    localparam logic [5:0] ADDR_CONTROL  = 6'h01;
    localparam logic [5:0] ADDR_DATA     = 6'h02;
    localparam logic [5:0] ADDR_CH_FIRST = 6'h09;
    localparam logic [5:0] ADDR_CH_LAST  = 6'h18;

    // Reset values
    localparam logic [15:0] CH0_RESET     = 16'h8001;
    localparam logic [15:0] CHN_RESET     = 16'h0001;
    localparam logic [15:0] CONTROL_RESET = 16'h0000;
    localparam logic [7:0]  STATUS_RESET  = 8'h80;

    // Channel register fields
    localparam int CH_ENABLE_BIT = 15;
    localparam int CH_SETUP_HI   = 14;
    localparam int CH_SETUP_LO   = 12;
    localparam int CH_POS_HI     = 9;
    localparam int CH_POS_LO     = 5;
    localparam int CH_NEG_HI     = 4;
    localparam int CH_NEG_LO     = 0;

    // Control, status and command fields
    localparam int CTRL_CONVERT_BIT  = 0;
    localparam int CTRL_APPEND_BIT   = 1;
    localparam int STAT_READY_N_BIT  = 7;
    localparam int STAT_CH_HI        = 3;
    localparam int STAT_CH_LO        = 0;
    localparam int CMD_READ_BIT      = 6;
    localparam logic [2:0] REG_BYTES = 3'd2;

    // Input source codes
    localparam logic [4:0] SRC_RSVD_FIRST = 5'h08;
    localparam logic [4:0] SRC_RSVD_LAST  = 5'h0F;
    localparam logic [4:0] SRC_TEMP       = 5'h10;
    localparam logic [4:0] SRC_NEG_SUPPLY = 5'h11;
    localparam logic [4:0] SRC_INT_REF    = 5'h12;
    localparam logic [4:0] SRC_DIG_GND    = 5'h13;
    localparam logic [4:0] SRC_MON_FIRST  = 5'h14;
    localparam logic [4:0] SRC_MON_LAST   = 5'h19;
    localparam logic [4:0] SRC_DIAG_LAST  = 5'h1D;

    typedef enum logic [1:0] {SEQ_IDLE, SEQ_START, SEQ_WAIT} acs_seq_e;

endpackage : acs_pkg

// *** acs_serial_port.sv ***
`timescale 1ns/100ps
module acs_serial_port
    import acs_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic       ce,
    input  wire logic       sclk_pin,
    input  wire logic       cs_n_pin,
    input  wire logic       sdi_pin,
    input  wire logic [7:0] tx_byte,
    output logic            frame_active,
    output logic            rx_valid,
    output logic [7:0]      rx_byte,
    output logic            sdo
);
    logic [2:0] sclk_sync, cs_sync, sdi_sync;
    logic       sclk_f, cs_f, sdi_f;
    logic       next_sclk_f, next_cs_f, next_sdi_f;
    logic [2:0] bit_cnt, next_bit_cnt;
    logic [7:0] rx_sh, next_rx_sh, tx_sh, next_tx_sh, next_rx_byte;
    logic       next_rx_valid, next_sdo, rise, fall;

    assign frame_active = !cs_f;

    // Filtered levels move only when stages two and three agree
    always_comb
    begin
        next_sclk_f = (sclk_sync[1] == sclk_sync[2]) ? sclk_sync[2] : sclk_f;
        next_cs_f   = (cs_sync[1] == cs_sync[2]) ? cs_sync[2] : cs_f;
        next_sdi_f  = (sdi_sync[1] == sdi_sync[2]) ? sdi_sync[2] : sdi_f;
        rise        = !sclk_f && next_sclk_f;
        fall        = sclk_f && !next_sclk_f;
        next_bit_cnt  = bit_cnt;
        next_rx_sh    = rx_sh;
        next_tx_sh    = tx_sh;
        next_rx_byte  = rx_byte;
        next_rx_valid = 1'b0;
        next_sdo      = sdo;
        if (cs_f)
        begin
            next_bit_cnt = 3'd0;
            next_sdo     = 1'b0;
        end
        else
        begin
            // Sample on the rising edge, most significant bit first
            if (rise)
            begin
                next_rx_sh   = {rx_sh[6:0], sdi_f};
                next_bit_cnt = bit_cnt + 3'd1;
                if (bit_cnt == 3'd7)
                begin
                    next_rx_valid = 1'b1;
                    next_rx_byte  = {rx_sh[6:0], sdi_f};
                end
            end
            // Launch on the falling edge; a new byte loads at the boundary
            if (fall)
            begin
                if (bit_cnt == 3'd0)
                    {next_sdo, next_tx_sh} = {tx_byte, 1'b0};
                else
                    {next_sdo, next_tx_sh} = {tx_sh, 1'b0};
            end
        end
    end

    // Idle bus is clock high, select high
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sclk_sync <= 3'h7;
            cs_sync   <= 3'h7;
            sdi_sync  <= 3'h0;
            sclk_f    <= 1'b1;
            cs_f      <= 1'b1;
            sdi_f     <= 1'b0;
            bit_cnt   <= 3'd0;
            rx_sh     <= 8'h00;
            tx_sh     <= 8'h00;
            rx_byte   <= 8'h00;
            rx_valid  <= 1'b0;
            sdo       <= 1'b0;
        end
        else if (ce)
        begin
            sclk_sync <= {sclk_sync[1:0], sclk_pin};
            cs_sync   <= {cs_sync[1:0], cs_n_pin};
            sdi_sync  <= {sdi_sync[1:0], sdi_pin};
            sclk_f    <= next_sclk_f;
            cs_f      <= next_cs_f;
            sdi_f     <= next_sdi_f;
            bit_cnt   <= next_bit_cnt;
            rx_sh     <= next_rx_sh;
            tx_sh     <= next_tx_sh;
            rx_byte   <= next_rx_byte;
            rx_valid  <= next_rx_valid;
            sdo       <= next_sdo;
        end
    end

endmodule : acs_serial_port

// *** acs_next_finder.sv ***
`timescale 1ns/100ps
module acs_next_finder
    import acs_pkg::*;
(
    input  wire logic [NUM_CH-1:0] en,
    input  wire logic [4:0]        from,
    output logic                   found,
    output logic [3:0]             idx
);
    logic [NUM_CH-1:0] ge;

    // Enabled channels at or above the search start
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ge
        assign ge[i] = en[i] && (5'(i) >= from);
    end

    // Lowest at or above start, else wrap to the lowest overall
    always_comb
    begin
        found = |en;
        idx   = 4'h0;
        for (int k = NUM_CH - 1; k >= 0; k--)
        begin
            if (en[k])
                idx = 4'(k);
        end
        for (int k = NUM_CH - 1; k >= 0; k--)
        begin
            if (ge[k])
                idx = 4'(k);
        end
    end

endmodule : acs_next_finder

// *** acs_channel_sequencer.sv ***
`timescale 1ns/100ps
module acs_channel_sequencer
    import acs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        ce,
    input  wire logic        sclk_pin,
    input  wire logic        cs_n_pin,
    input  wire logic        sdi_pin,
    output logic             sdo,
    input  wire logic        conv_done,
    input  wire logic [23:0] conv_result,
    output logic             conv_start,
    output logic [3:0]       conv_channel,
    output logic [2:0]       conv_setup,
    output logic [4:0]       positive_input_select,
    output logic [4:0]       negative_input_select,
    output logic             conv_diag_src,
    output logic             conv_reserved_src,
    output logic             seq_active
);
    logic [15:0]       chan [NUM_CH];
    logic [15:0]       next_chan [NUM_CH];
    logic [NUM_CH-1:0] en_vec, prev_en;
    logic [15:0]       control, next_control;
    logic [2:0]        byte_idx, next_byte_idx;
    logic              cmd_rd, next_cmd_rd;
    logic [5:0]        cmd_addr, next_cmd_addr;
    logic [39:0]       rd_buf, next_rd_buf, rd_word;
    logic [7:0]        wr_buf, next_wr_buf;
    logic              data_read, frame_active, rx_valid;
    logic [7:0]        rx_byte;
    logic [5:0]        req_addr;
    acs_seq_e          state, next_state;
    logic [3:0]        cur, next_cur, found_idx;
    logic              found;
    logic [4:0]        search_from;
    logic [23:0]       result, next_result;
    logic [7:0]        status, next_status;
    logic              next_start, next_diag, next_rsvd;
    logic [3:0]        next_conv_channel;
    logic [2:0]        next_setup;
    logic [4:0]        next_pos, next_neg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    function automatic logic ch_hit(input logic [5:0] a);
        return (a >= ADDR_CH_FIRST) && (a <= ADDR_CH_LAST);
    endfunction : ch_hit

    function automatic logic [3:0] ch_of(input logic [5:0] a);
        return 4'(a - ADDR_CH_FIRST);
    endfunction : ch_of

    function automatic logic is_diag(input logic [4:0] c);
        return (c >= SRC_TEMP) && (c <= SRC_DIAG_LAST);
    endfunction : is_diag

    function automatic logic is_rsvd(input logic [4:0] c);
        return ((c >= SRC_RSVD_FIRST) && (c <= SRC_RSVD_LAST)) || (c > SRC_DIAG_LAST);
    endfunction : is_rsvd

    acs_serial_port u_port (
        .clk          (clk),
        .srst         (srst),
        .ce           (ce),
        .sclk_pin     (sclk_pin),
        .cs_n_pin     (cs_n_pin),
        .sdi_pin      (sdi_pin),
        .tx_byte      (rd_buf[39:32]),
        .frame_active (frame_active),
        .rx_valid     (rx_valid),
        .rx_byte      (rx_byte),
        .sdo          (sdo)
    );

    acs_next_finder u_find (
        .en    (en_vec),
        .from  (search_from),
        .found (found),
        .idx   (found_idx)
    );

    // Enable bit of each channel feeds the sequencer
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_en
        assign en_vec[i] = chan[i][CH_ENABLE_BIT];
    end

    // Read word, left aligned, picked from the command byte address
    always_comb
    begin
        req_addr = rx_byte[5:0];
        rd_word  = 40'h0;
        if (ch_hit(req_addr))
            rd_word = {chan[ch_of(req_addr)], 24'h0};
        else if (req_addr == ADDR_STATUS)
            rd_word = {status, 32'h0};
        else if (req_addr == ADDR_CONTROL)
            rd_word = {control, 24'h0};
        else if (req_addr == ADDR_DATA)
        begin
            if (control[CTRL_APPEND_BIT])
                rd_word = {result, status, 8'h00};
            else
                rd_word = {result, 16'h0};
        end
    end

    // Host frame: command byte, then data bytes; unmapped reads give zero
    always_comb
    begin
        next_chan     = chan;
        next_control  = control;
        next_byte_idx = byte_idx;
        next_cmd_rd   = cmd_rd;
        next_cmd_addr = cmd_addr;
        next_rd_buf   = rd_buf;
        next_wr_buf   = wr_buf;
        data_read     = 1'b0;
        if (!frame_active)
            next_byte_idx = 3'd0;
        else if (rx_valid)
        begin
            if (byte_idx != 3'd7)
                next_byte_idx = byte_idx + 3'd1;
            if (byte_idx == 3'd0)
            begin
                next_cmd_rd   = rx_byte[CMD_READ_BIT];
                next_cmd_addr = req_addr;
                next_rd_buf   = rx_byte[CMD_READ_BIT] ? rd_word : 40'h0;
                data_read     = rx_byte[CMD_READ_BIT] && (req_addr == ADDR_DATA);
            end
            else if (cmd_rd)
                next_rd_buf = {rd_buf[31:0], 8'h00};
            else
            begin
                next_wr_buf = rx_byte;
                // Word commits on its second byte; extra bytes are ignored
                if (byte_idx == REG_BYTES)
                begin
                    // Bits 11:10 are stored as written; software keeps them zero
                    if (ch_hit(cmd_addr))
                        next_chan[ch_of(cmd_addr)] = {wr_buf, rx_byte};
                    else if (cmd_addr == ADDR_CONTROL)
                        next_control = {wr_buf, rx_byte};
                end
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            for (int k = 0; k < NUM_CH; k++)
                chan[k] <= (k == 0) ? CH0_RESET : CHN_RESET;
            control  <= CONTROL_RESET;
            byte_idx <= 3'd0;
            cmd_rd   <= 1'b0;
            cmd_addr <= 6'h00;
            rd_buf   <= 40'h0;
            wr_buf   <= 8'h00;
        end
        else if (ce)
        begin
            chan     <= next_chan;
            control  <= next_control;
            byte_idx <= next_byte_idx;
            cmd_rd   <= next_cmd_rd;
            cmd_addr <= next_cmd_addr;
            rd_buf   <= next_rd_buf;
            wr_buf   <= next_wr_buf;
        end
    end

    // Search from the slot after the current one while waiting, from zero otherwise
    assign search_from = (state == SEQ_WAIT) ? ({1'b0, cur} + 5'd1) : 5'd0;

    // Sequencer; each enabled register is visited once per pass
    always_comb
    begin
        next_state        = state;
        next_cur          = cur;
        next_start        = 1'b0;
        next_conv_channel = conv_channel;
        next_setup        = conv_setup;
        next_pos          = positive_input_select;
        next_neg          = negative_input_select;
        next_diag         = conv_diag_src;
        next_rsvd         = conv_reserved_src;
        next_result       = result;
        next_status       = status;
        if (data_read)
            next_status[STAT_READY_N_BIT] = 1'b1;
        case (state)
            SEQ_IDLE:
                if (control[CTRL_CONVERT_BIT] && found)
                begin
                    next_cur   = found_idx;
                    next_state = SEQ_START;
                end
            SEQ_START:
            begin
                next_start        = 1'b1;
                next_conv_channel = cur;
                next_setup        = chan[cur][CH_SETUP_HI:CH_SETUP_LO];
                next_pos          = chan[cur][CH_POS_HI:CH_POS_LO];
                next_neg          = chan[cur][CH_NEG_HI:CH_NEG_LO];
                // Flag internal and monitor sources; reserved codes are reported
                next_diag  = is_diag(next_pos) || is_diag(next_neg);
                next_rsvd  = is_rsvd(next_pos) || is_rsvd(next_neg);
                next_state = SEQ_WAIT;
            end
            SEQ_WAIT:
                if (conv_done)
                begin
                    next_result = conv_result;
                    next_status[STAT_CH_HI:STAT_CH_LO] = cur;
                    // A fresh result wins over a read clearing the flag
                    next_status[STAT_READY_N_BIT] = 1'b0;
                    if (control[CTRL_CONVERT_BIT] && found)
                    begin
                        next_cur   = found_idx;
                        next_state = SEQ_START;
                    end
                    else
                        next_state = SEQ_IDLE;
                end
            default:
                next_state = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            state                 <= SEQ_IDLE;
            cur                   <= 4'h0;
            conv_start            <= 1'b0;
            conv_channel          <= 4'h0;
            conv_setup            <= 3'h0;
            positive_input_select <= 5'h00;
            negative_input_select <= 5'h01;
            conv_diag_src         <= 1'b0;
            conv_reserved_src     <= 1'b0;
            seq_active            <= 1'b0;
            result                <= 24'h0;
            status                <= STATUS_RESET;
            prev_en               <= 16'h0;
        end
        else if (ce)
        begin
            state                 <= next_state;
            cur                   <= next_cur;
            conv_start            <= next_start;
            conv_channel          <= next_conv_channel;
            conv_setup            <= next_setup;
            positive_input_select <= next_pos;
            negative_input_select <= next_neg;
            conv_diag_src         <= next_diag;
            conv_reserved_src     <= next_rsvd;
            seq_active            <= (next_state != SEQ_IDLE);
            result                <= next_result;
            status                <= next_status;
            prev_en               <= en_vec;
        end
    end

    sequence s_done_and_more;
        ce && state == SEQ_WAIT && conv_done && control[CTRL_CONVERT_BIT] && found;
    endsequence

    sequence s_cmd_read(logic [5:0] a);
        ce && rx_valid && frame_active && byte_idx == 3'd0 && rx_byte[CMD_READ_BIT] && rx_byte[5:0] == a;
    endsequence

    chk_reset_values: assert property (@(posedge clk) $fell(srst) |-> chan[0] == CH0_RESET && chan[5] == CHN_RESET)
        else $error("channel reset values wrong");
    chk_addr_top: assert property (s_cmd_read(ADDR_CH_LAST) |=> rd_buf[39:24] == $past(chan[15]))
        else $error("last channel address does not map to channel fifteen");
    chk_slot_enabled: assert property (ce && state == SEQ_START && $past(state) != SEQ_START |-> prev_en[cur])
        else $error("sequencer picked a disabled channel");
    chk_ascend_wrap: assert property (s_done_and_more |=> cur > $past(cur)
        || ($past(en_vec) >> ({1'b0, $past(cur)} + 5'd1)) == 16'h0)
        else $error("sequence skipped or went backward");
    chk_status_tag: assert property (ce && state == SEQ_WAIT && conv_done |=> status[3:0] == $past(cur) && !status[7])
        else $error("status channel tag wrong");
    chk_append_status: assert property (s_cmd_read(ADDR_DATA) ##0 control[CTRL_APPEND_BIT]
        |=> rd_buf[15:8] == $past(status))
        else $error("status not appended to data read");
    // Selects are taken in the start cycle; a later host write must not trip this
    chk_setup_route: assert property (conv_start |-> conv_channel == $past(cur)
        && conv_setup == $past(chan[cur][CH_SETUP_HI:CH_SETUP_LO])
        && positive_input_select == $past(chan[cur][CH_POS_HI:CH_POS_LO]))
        else $error("setup or positive select not routed");
    chk_neg_route: assert property (conv_start |-> negative_input_select == $past(chan[cur][CH_NEG_HI:CH_NEG_LO]))
        else $error("negative select not routed");
    chk_start_pulse: assert property (ce && state == SEQ_START |=> conv_start ##1 !conv_start)
        else $error("start pulse malformed");
    chk_idle_none: assert property (ce && state == SEQ_IDLE && en_vec == 16'h0 |=> state == SEQ_IDLE && !conv_start)
        else $error("conversion started with no channel enabled");
    chk_msb_first: assert property (ce && rx_valid && frame_active && !cmd_rd && byte_idx == 3'd2
        && cmd_addr == ADDR_CH_FIRST
        |=> chan[0] == {$past(wr_buf), $past(rx_byte)})
        else $error("channel word not assembled high byte first");

endmodule : acs_channel_sequencer

// *** acs_host_model.sv ***
`timescale 1ns/100ps
// Serial host in mode 3: clock idles high, bytes go out MSB first
module acs_host_model
(
    input  wire logic clk,
    input  wire logic sdo,
    output logic      sclk_pin,
    output logic      cs_n_pin,
    output logic      sdi_pin
);
    // Idle lines: clock and select stay high between frames
    initial
    begin
        sclk_pin = 1'b1;
        cs_n_pin = 1'b1;
        sdi_pin  = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // Six-cycle phases clear the three-flop pin filter with margin
    task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--)
        begin
            sclk_pin = 1'b0;
            sdi_pin  = tx[i];
            tick(6);
            rx[i]    = sdo;
            sclk_pin = 1'b1;
            tick(6);
        end
    endtask : xbyte

    // Released data line shows the inverse, so a stale bit cannot pass
    task automatic close_frame();
        tick(6);
        cs_n_pin = 1'b1;
        sdi_pin  = ~sdi_pin;
        tick(6);
    endtask : close_frame

    task automatic wr16(input logic [5:0] addr, input logic [15:0] val);
        logic [7:0] b;
        cs_n_pin = 1'b0;
        tick(6);
        xbyte({2'b00, addr}, b);
        xbyte(val[15:8], b);
        xbyte(val[7:0], b);
        close_frame();
    endtask : wr16

    // Four bytes always; bytes past the register read as zero
    task automatic rd32(input logic [5:0] addr, output logic [31:0] val);
        logic [7:0] b;
        cs_n_pin = 1'b0;
        tick(6);
        xbyte({2'b01, addr}, b);
        for (int k = 3; k >= 0; k--)
        begin
            xbyte(8'h00, b);
            val[k*8 +: 8] = b;
        end
        close_frame();
    endtask : rd32
endmodule : acs_host_model

// *** tb_top.sv ***
`timescale 1ns/100ps
module tb_top;
    import acs_pkg::*;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic        sclk_pin, cs_n_pin, sdi_pin, sdo;
    logic        conv_done = 1'b0;
    logic [23:0] conv_result = 24'h000000;
    logic        conv_start, conv_diag_src, conv_reserved_src, seq_active;
    logic [3:0]  conv_channel;
    logic [2:0]  conv_setup;
    logic [4:0]  positive_input_select, negative_input_select;
    logic [18:0] starts[$];
    logic [31:0] rv;
    logic [15:0] tv[6] = '{16'h0001, 16'h9213, 16'hF064, 16'h8114, 16'hA064, 16'hB319};
    int          tc[6] = '{0, 2, 5, 9, 13, 15};
    int          bad_count = 0;
    int          checks = 0;

    // 50 MHz clock
    always #10 clk = ~clk;

    acs_channel_sequencer acs_channel_sequencer_inst (.clk(clk), .srst(srst), .ce(1'b1),
        .sclk_pin(sclk_pin), .cs_n_pin(cs_n_pin), .sdi_pin(sdi_pin), .sdo(sdo),
        .conv_done(conv_done), .conv_result(conv_result), .conv_start(conv_start),
        .conv_channel(conv_channel), .conv_setup(conv_setup),
        .positive_input_select(positive_input_select), .negative_input_select(negative_input_select),
        .conv_diag_src(conv_diag_src), .conv_reserved_src(conv_reserved_src), .seq_active(seq_active));

    acs_host_model acs_host_model_inst (.clk(clk), .sdo(sdo), .sclk_pin(sclk_pin),
        .cs_n_pin(cs_n_pin), .sdi_pin(sdi_pin));

    // Log each start pulse; it may fall inside a serial frame
    always @(posedge clk)
        if (conv_start === 1'b1)
            starts.push_back({conv_channel, conv_setup, positive_input_select,
                              negative_input_select, conv_diag_src, conv_reserved_src});

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    // Source class: bit1 diagnostic, bit0 reserved
    function automatic logic [1:0] src_class(input logic [4:0] s);
        return {s >= SRC_TEMP && s <= SRC_DIAG_LAST,
                s >= SRC_RSVD_FIRST && (s <= SRC_RSVD_LAST || s > SRC_DIAG_LAST)};
    endfunction : src_class

    task automatic expect_conv(input int ch, input logic [15:0] v);
        logic [1:0] p;
        logic [1:0] n;
        p = src_class(v[9:5]);
        n = src_class(v[4:0]);
        for (int k = 0; k < 3000 && starts.size() == 0; k++)
            tick(1);
        if (starts.size() == 0)
        begin
            bad_count++;
            $display("MISMATCH conv_start expected channel %0d seen none", ch);
            final_report();
        end
        chk("conv_selects", {13'h0, 4'(ch), v[14:12], v[9:5], v[4:0], p[1] | n[1], p[0] | n[0]},
            {13'h0, starts.pop_front()});
    endtask : expect_conv

    // Converter side: result held only during the strobe
    task automatic done(input logic [23:0] r);
        tick(3);
        conv_result = r;
        conv_done   = 1'b1;
        tick(1);
        conv_done   = 1'b0;
        conv_result = ~r;
    endtask : done

    task automatic t_reset();
        for (int k = 0; k < 16; k++)
        begin
            acs_host_model_inst.rd32(ADDR_CH_FIRST + 6'(k), rv);
            chk("ch_reset", {k == 0 ? CH0_RESET : CHN_RESET, 16'h0000}, rv);
        end
        acs_host_model_inst.rd32(6'h3F, rv);
        chk("unmapped", 32'h0, rv);
        chk("sel_reset", {21'h0, 1'b0, 5'h00, 5'h01},
            {21'h0, seq_active, positive_input_select, negative_input_select});
        $display("test reset done");
    endtask : t_reset

    // Bits 11:10 kept zero in every value written
    task automatic t_fields();
        for (int i = 0; i < 6; i++)
            acs_host_model_inst.wr16(ADDR_CH_FIRST + 6'(tc[i]), tv[i]);
        for (int i = 0; i < 6; i++)
        begin
            acs_host_model_inst.rd32(ADDR_CH_FIRST + 6'(tc[i]), rv);
            chk("ch_readback", {tv[i], 16'h0000}, rv);
        end
        acs_host_model_inst.wr16(ADDR_STATUS, 16'h1234);
        acs_host_model_inst.rd32(ADDR_STATUS, rv);
        chk("status_ro", {STATUS_RESET, 24'h0}, rv);
        $display("test fields done");
    endtask : t_fields

    task automatic t_sequence();
        acs_host_model_inst.wr16(ADDR_CONTROL, 16'h0001);
        for (int i = 0; i < 6; i++)
        begin
            expect_conv(tc[i % 5 + 1], tv[i % 5 + 1]);
            done(24'h100000 + 24'(i));
            acs_host_model_inst.rd32(ADDR_STATUS, rv);
            chk("status_ch", {28'h0, 4'(tc[i % 5 + 1])}, {28'h0, rv[27:24]});
        end
        $display("test sequence done");
    endtask : t_sequence

    task automatic t_append();
        acs_host_model_inst.rd32(ADDR_DATA, rv);
        chk("data_plain", {24'h100005, 8'h00}, rv);
        acs_host_model_inst.wr16(ADDR_CONTROL, 16'h0003);
        expect_conv(5, tv[2]);
        chk("seq_busy", 32'h1, 32'(seq_active));
        done(24'hA5C3E1);
        acs_host_model_inst.rd32(ADDR_DATA, rv);
        chk("data_status", {24'hA5C3E1, 8'h05}, {rv[31:8], 4'h0, rv[3:0]});
        $display("test append done");
    endtask : t_append

    // Pending conversion finishes, then nothing may start until channel 7 is enabled
    task automatic t_idle();
        expect_conv(9, tv[3]);
        for (int i = 1; i < 6; i++)
            acs_host_model_inst.wr16(ADDR_CH_FIRST + 6'(tc[i]), tv[i] & 16'h7FFF);
        done(24'h000000);
        tick(300);
        chk("no_start", 32'h0, 32'(starts.size()));
        chk("seq_idle", 32'h0, 32'(seq_active));
        acs_host_model_inst.wr16(ADDR_CH_FIRST + 6'd7, 16'hC03E);
        expect_conv(7, 16'hC03E);
        $display("test idle done");
    endtask : t_idle

    // Reset for four cycles, then the scenarios in order
    initial
    begin
        repeat (4) @(posedge clk);
        #1 srst = 1'b0;
        tick(1);
        t_reset();
        t_fields();
        t_sequence();
        t_append();
        t_idle();
        final_report();
    end
endmodule : tb_top
